/* common/rps_pkg.sv */
package rps_pkg;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int FIELD_W = 6;
	localparam int FIELD_LO_LSB = 0;
	localparam int FIELD_HI_LSB = 8;
	localparam int LOCK_BIT_POS = 6;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [5:0] IN_SEL_RST = 6'h3F;
	localparam logic [5:0] OUT_SEL_RST = 6'h00;
	localparam logic LOCK_RST = 1'b0;

	// ----------------------------------------
	// Unlock keys and pin limits
	// ----------------------------------------
	localparam logic [7:0] UNLOCK_KEY_ONE = 8'h46;
	localparam logic [7:0] UNLOCK_KEY_TWO = 8'h57;
	localparam logic [5:0] MAX_PIN_NUM = 6'h2B;
	localparam int BIDIR_PINS = 32;
	localparam int INPUT_ONLY_PINS = 12;
	localparam int SEL_SPAN = 64;

	// ----------------------------------------
	// Output function codes
	// ----------------------------------------
	localparam logic [5:0] CODE_NULL = 6'h00;
	localparam logic [5:0] CODE_CMP_ONE = 6'h01;
	localparam logic [5:0] CODE_CMP_TWO = 6'h02;
	localparam logic [5:0] CODE_SER1_TX = 6'h03;
	localparam logic [5:0] CODE_SER1_RTS = 6'h04;
	localparam logic [5:0] CODE_SER2_TX = 6'h05;
	localparam logic [5:0] CODE_SER2_RTS = 6'h06;
	localparam logic [5:0] CODE_SPI1_DO = 6'h07;
	localparam logic [5:0] CODE_SPI1_CK = 6'h08;
	localparam logic [5:0] CODE_SPI1_SS = 6'h09;
	localparam logic [5:0] CODE_SPI2_DO = 6'h0A;
	localparam logic [5:0] CODE_SPI2_CK = 6'h0B;
	localparam logic [5:0] CODE_SPI2_SS = 6'h0C;
	localparam logic [5:0] CODE_CMPU_FIRST = 6'h12;
	localparam logic [5:0] CODE_SER3_TX = 6'h1C;
	localparam logic [5:0] CODE_SER3_RTS = 6'h1D;
	localparam logic [5:0] CODE_SER4_TX = 6'h1E;
	localparam logic [5:0] CODE_SER4_RTS = 6'h1F;
	localparam logic [5:0] CODE_SPI3_DO = 6'h20;
	localparam logic [5:0] CODE_SPI3_CK = 6'h21;
	localparam logic [5:0] CODE_SPI3_SS = 6'h22;
	localparam logic [5:0] CODE_CMPU_NINE = 6'h23;
	localparam logic [5:0] CODE_CMP_THREE = 6'h24;
	// One bit per code that drives a function
	localparam logic [63:0] OUT_CODE_VALID = 64'h0000_001F_F3FC_1FFE;

	// ----------------------------------------
	// Unlock sequence states
	// ----------------------------------------
	typedef enum logic [1:0] {UNL_IDLE, UNL_KEY_ONE, UNL_KEY_TWO} rps_unlock_type;

endpackage

/* hw/rps_in_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_in_mux #(
	parameter int NUM_PINS = 44,
	parameter logic [63:0] IMPL_PIN_MASK = 64'h0000_0FFF_FFFF_FFFF
) (
	// Selector
	input wire logic [5:0] sel,
	// Pins and result
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic mux_out
);
	logic [63:0] pins_ext;

	always_comb begin
		pins_ext = '0;
		pins_ext[NUM_PINS-1:0] = pin_in;
		// Absent or out-of-range pin gives a low input
		if ((sel <= rps_pkg::MAX_PIN_NUM) && IMPL_PIN_MASK[sel]) begin // [RULE_11]
			mux_out = pins_ext[sel]; // [RULE_17]
		end else begin
			mux_out = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* hw/rps_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE_01] Codes 1,2,36 comparators; 18-25,35 compare units
// [RULE_02] Codes 3-6 serial one/two transmit, request-to-send
// [RULE_03] Codes 28-31 serial three/four transmit, request
// [RULE_04] Codes 7-12 first and second SPI outputs
// [RULE_05] Codes 32-34 third SPI data, clock, select
// [RULE_06] Code zero disconnects pin; reset value
// [RULE_07] Infrared bit clock replaces request-to-send output
// [RULE_08] One source per pin, one pin per input
// [RULE_09] Fan-out both ways works concurrently
// [RULE_10] 64 codes span, 44 pins, 12 input-only
// [RULE_11] Input selector above 43 or absent: no pin
// [RULE_12] Output fields of absent pins ignore writes
// [RULE_13] Locked selector writes accepted but discarded
// [RULE_14] Lock bit is control register bit 6
// [RULE_15] Keys 46h then 57h, then lock write
// [RULE_16] Lock holds its state, no automatic relock
// [RULE_17] Input register has two 6-bit fields
// [RULE_18] Reset: inputs all ones, outputs all zeros
// [RULE_19] One-way mode: only reset clears lock
// [RULE_20] Unused output codes behave as null
// [RULE_21] Wrong write in sequence abandons unlock
module rps_top #(
	parameter int NUM_PINS = 44,
	parameter int OUT_REGS = 16,
	parameter int IN_REGS = 30,
	parameter logic [63:0] IMPL_PIN_MASK = 64'h0000_0FFF_FFFF_FFFF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Oscillator control register low byte writes
	input wire logic osc_wr_en,
	input wire logic [7:0] osc_wr_data,
	input wire logic one_way_lock_config,
	output logic pin_select_lock_bit,
	// Selector register writes
	input wire logic sel_wr_en,
	input wire logic sel_wr_is_input,
	input wire logic [4:0] sel_wr_index,
	input wire logic [15:0] sel_wr_data,
	output logic [2*OUT_REGS*6-1:0] pin_output_selector_reg,
	output logic [2*IN_REGS*6-1:0] peripheral_input_selector_reg,
	// Peripheral outputs
	input wire logic comparator_one_out,
	input wire logic comparator_two_out,
	input wire logic comparator_three_out,
	input wire logic serial_one_transmit,
	input wire logic serial_one_request_to_send,
	input wire logic serial_two_transmit,
	input wire logic serial_two_request_to_send,
	input wire logic serial_three_transmit,
	input wire logic serial_three_request_to_send,
	input wire logic serial_four_transmit,
	input wire logic serial_four_request_to_send,
	input wire logic spi_one_data_out,
	input wire logic spi_one_clock_out,
	input wire logic spi_one_select_out,
	input wire logic spi_two_data_out,
	input wire logic spi_two_clock_out,
	input wire logic spi_two_select_out,
	input wire logic spi_three_data_out,
	input wire logic spi_three_clock_out,
	input wire logic spi_three_select_out,
	input wire logic [8:0] compare_unit_out,
	// Infrared encoders, one per serial port
	input wire logic [3:0] infrared_active,
	input wire logic [3:0] infrared_bit_clock,
	// Remappable pins
	input wire logic [NUM_PINS-1:0] remappable_pin_in,
	output logic [rps_pkg::BIDIR_PINS-1:0] remappable_pin_out,
	output logic [rps_pkg::BIDIR_PINS-1:0] remappable_pin_oe_n,
	// Peripheral inputs
	output logic [2*IN_REGS-1:0] peripheral_in
);
	localparam int OUT_FIELDS = 2 * OUT_REGS;
	localparam int IN_FIELDS = 2 * IN_REGS;

	typedef struct packed {
		rps_pkg::rps_unlock_type unl;
		logic lock;
		logic [OUT_FIELDS-1:0][5:0] out_sel;
		logic [IN_FIELDS-1:0][5:0] in_sel;
		logic [OUT_FIELDS-1:0] pin_out;
		logic [OUT_FIELDS-1:0] pin_oe_n;
		logic [IN_FIELDS-1:0] periph_in;
	} rps_state_type;

	rps_state_type s_r;
	rps_state_type s_nxt;
	logic [63:0] src;
	logic [IN_FIELDS-1:0] mux_res;

	function automatic logic [5:0] get_field(input logic [15:0] data, input logic hi);
		get_field = hi ? data[rps_pkg::FIELD_HI_LSB +: rps_pkg::FIELD_W]
			: data[rps_pkg::FIELD_LO_LSB +: rps_pkg::FIELD_W];
	endfunction

	// ----------------------------------------
	// Output function sources by code
	// ----------------------------------------
	always_comb begin
		src = '0; // [RULE_20]
		src[rps_pkg::CODE_CMP_ONE] = comparator_one_out; // [RULE_01]
		src[rps_pkg::CODE_CMP_TWO] = comparator_two_out; // [RULE_01]
		src[rps_pkg::CODE_CMP_THREE] = comparator_three_out; // [RULE_01]
		for (int i = 0; i < 8; i++) begin
			src[rps_pkg::CODE_CMPU_FIRST + 6'(i)] = compare_unit_out[i]; // [RULE_01]
		end
		src[rps_pkg::CODE_CMPU_NINE] = compare_unit_out[8]; // [RULE_01]
		src[rps_pkg::CODE_SER1_TX] = serial_one_transmit; // [RULE_02]
		src[rps_pkg::CODE_SER2_TX] = serial_two_transmit; // [RULE_02]
		src[rps_pkg::CODE_SER3_TX] = serial_three_transmit; // [RULE_03]
		src[rps_pkg::CODE_SER4_TX] = serial_four_transmit; // [RULE_03]
		// Bit clock takes over the request-to-send code
		src[rps_pkg::CODE_SER1_RTS] = infrared_active[0] ? infrared_bit_clock[0]
			: serial_one_request_to_send; // [RULE_02] [RULE_07]
		src[rps_pkg::CODE_SER2_RTS] = infrared_active[1] ? infrared_bit_clock[1]
			: serial_two_request_to_send; // [RULE_02] [RULE_07]
		src[rps_pkg::CODE_SER3_RTS] = infrared_active[2] ? infrared_bit_clock[2]
			: serial_three_request_to_send; // [RULE_03] [RULE_07]
		src[rps_pkg::CODE_SER4_RTS] = infrared_active[3] ? infrared_bit_clock[3]
			: serial_four_request_to_send; // [RULE_03] [RULE_07]
		src[rps_pkg::CODE_SPI1_DO] = spi_one_data_out; // [RULE_04]
		src[rps_pkg::CODE_SPI1_CK] = spi_one_clock_out; // [RULE_04]
		src[rps_pkg::CODE_SPI1_SS] = spi_one_select_out; // [RULE_04]
		src[rps_pkg::CODE_SPI2_DO] = spi_two_data_out; // [RULE_04]
		src[rps_pkg::CODE_SPI2_CK] = spi_two_clock_out; // [RULE_04]
		src[rps_pkg::CODE_SPI2_SS] = spi_two_select_out; // [RULE_04]
		src[rps_pkg::CODE_SPI3_DO] = spi_three_data_out; // [RULE_05]
		src[rps_pkg::CODE_SPI3_CK] = spi_three_clock_out; // [RULE_05]
		src[rps_pkg::CODE_SPI3_SS] = spi_three_select_out; // [RULE_05]
	end

	// ----------------------------------------
	// Input muxes, one per peripheral input
	// ----------------------------------------
	for (genvar g = 0; g < IN_FIELDS; g++) begin : g_in
		rps_in_mux #(
			.NUM_PINS(NUM_PINS),
			.IMPL_PIN_MASK(IMPL_PIN_MASK)
		) u_mux (
			.sel(s_r.in_sel[g]),
			.pin_in(remappable_pin_in),
			.mux_out(mux_res[g])
		);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Unlock sequence on control register writes
		if (osc_wr_en) begin
			unique case (s_r.unl)
				rps_pkg::UNL_IDLE: begin
					s_nxt.unl = (osc_wr_data == rps_pkg::UNLOCK_KEY_ONE)
						? rps_pkg::UNL_KEY_ONE : rps_pkg::UNL_IDLE; // [RULE_15]
				end
				rps_pkg::UNL_KEY_ONE: begin
					s_nxt.unl = (osc_wr_data == rps_pkg::UNLOCK_KEY_TWO)
						? rps_pkg::UNL_KEY_TWO : rps_pkg::UNL_IDLE; // [RULE_15] [RULE_21]
				end
				rps_pkg::UNL_KEY_TWO: begin
					s_nxt.unl = rps_pkg::UNL_IDLE;
					if (!(one_way_lock_config && s_r.lock)) begin // [RULE_19]
						s_nxt.lock = osc_wr_data[rps_pkg::LOCK_BIT_POS]; // [RULE_14] [RULE_15]
					end
				end
				default: begin
					s_nxt.unl = rps_pkg::UNL_IDLE;
				end
			endcase
		end
		// Selector writes, discarded while locked
		if (sel_wr_en && !s_r.lock) begin // [RULE_13]
			for (int h = 0; h < 2; h++) begin
				if (sel_wr_is_input && (int'(sel_wr_index) < IN_REGS)) begin
					s_nxt.in_sel[2*sel_wr_index+h] = get_field(sel_wr_data, h[0]); // [RULE_17]
				end
				if (!sel_wr_is_input && (int'(sel_wr_index) < OUT_REGS)
					&& IMPL_PIN_MASK[2*sel_wr_index+h]) begin // [RULE_12]
					s_nxt.out_sel[2*sel_wr_index+h] = get_field(sel_wr_data, h[0]);
				end
			end
		end
		// Each pin picks one source; sources fan out freely
		for (int p = 0; p < OUT_FIELDS; p++) begin
			s_nxt.pin_out[p] = src[s_r.out_sel[p]]; // [RULE_08] [RULE_09]
			s_nxt.pin_oe_n[p] = !rps_pkg::OUT_CODE_VALID[s_r.out_sel[p]]; // [RULE_06] [RULE_20]
		end
		s_nxt.periph_in = mux_res; // [RULE_09] [RULE_10]
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_r.unl <= rps_pkg::UNL_IDLE;
			s_r.lock <= rps_pkg::LOCK_RST;
			s_r.out_sel <= {OUT_FIELDS{rps_pkg::OUT_SEL_RST}}; // [RULE_06] [RULE_18]
			s_r.in_sel <= {IN_FIELDS{rps_pkg::IN_SEL_RST}}; // [RULE_18]
			s_r.pin_out <= '0;
			s_r.pin_oe_n <= '1;
			s_r.periph_in <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pin_select_lock_bit = s_r.lock;
	assign pin_output_selector_reg = s_r.out_sel;
	assign peripheral_input_selector_reg = s_r.in_sel;
	assign remappable_pin_out = s_r.pin_out;
	assign remappable_pin_oe_n = s_r.pin_oe_n;
	assign peripheral_in = s_r.periph_in;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_null_code;
		s_r.out_sel[0] == rps_pkg::CODE_NULL |=> remappable_pin_oe_n[0] && !remappable_pin_out[0];
	endproperty
	a_null_code: assert property (p_null_code) else $error("null code drives pin"); // [RULE_06]

	property p_cmp_one;
		s_r.out_sel[0] == rps_pkg::CODE_CMP_ONE
			|=> !remappable_pin_oe_n[0] && remappable_pin_out[0] == $past(comparator_one_out);
	endproperty
	a_cmp_one: assert property (p_cmp_one) else $error("comparator one not routed"); // [RULE_01]

	property p_ser1_tx;
		s_r.out_sel[1] == rps_pkg::CODE_SER1_TX
			|=> remappable_pin_out[1] == $past(serial_one_transmit);
	endproperty
	a_ser1_tx: assert property (p_ser1_tx) else $error("serial one transmit not routed"); // [RULE_02]

	property p_infrared;
		s_r.out_sel[2] == rps_pkg::CODE_SER3_RTS && infrared_active[2]
			|=> remappable_pin_out[2] == $past(infrared_bit_clock[2]);
	endproperty
	a_infrared: assert property (p_infrared) else $error("bit clock not on pin"); // [RULE_07]

	property p_locked_write;
		s_r.lock && sel_wr_en |=> $stable(pin_output_selector_reg)
			&& $stable(peripheral_input_selector_reg);
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("locked selector changed"); // [RULE_13]

	property p_unlock;
		s_r.unl == rps_pkg::UNL_KEY_TWO && osc_wr_en && !one_way_lock_config
			|=> pin_select_lock_bit == $past(osc_wr_data[rps_pkg::LOCK_BIT_POS]);
	endproperty
	a_unlock: assert property (p_unlock) else $error("lock write not taken"); // [RULE_15]

	property p_abandon;
		s_r.unl == rps_pkg::UNL_KEY_ONE && osc_wr_en && osc_wr_data != rps_pkg::UNLOCK_KEY_TWO
			|=> s_r.unl == rps_pkg::UNL_IDLE ##1 $stable(pin_select_lock_bit);
	endproperty
	a_abandon: assert property (p_abandon) else $error("broken sequence kept"); // [RULE_21]

	property p_hold_lock;
		!(osc_wr_en && s_r.unl == rps_pkg::UNL_KEY_TWO) |=> $stable(pin_select_lock_bit);
	endproperty
	a_hold_lock: assert property (p_hold_lock) else $error("lock changed on its own"); // [RULE_16]

	property p_one_way;
		one_way_lock_config && pin_select_lock_bit |=> pin_select_lock_bit;
	endproperty
	a_one_way: assert property (p_one_way) else $error("one-way lock cleared"); // [RULE_19]

	property p_bad_input;
		s_r.in_sel[0] > rps_pkg::MAX_PIN_NUM |=> !peripheral_in[0];
	endproperty
	a_bad_input: assert property (p_bad_input) else $error("invalid pin reached input"); // [RULE_11]

	property p_unused_code;
		s_r.out_sel[1] == 6'h0D |=> remappable_pin_oe_n[1] && !remappable_pin_out[1];
	endproperty
	a_unused_code: assert property (p_unused_code) else $error("unused code drives pin"); // [RULE_20]

	c_unlock: cover property (s_r.unl == rps_pkg::UNL_KEY_TWO && osc_wr_en);
	c_lock_set: cover property ($rose(pin_select_lock_bit));
	c_pin_drive: cover property (!remappable_pin_oe_n[0]);
	c_input_map: cover property (s_r.in_sel[0] <= rps_pkg::MAX_PIN_NUM && peripheral_in[0]);
endmodule
`default_nettype wire

/* tb/rps_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_periph_model (
	// Clock
	input wire logic ref_clk,
	// Levels chosen by the bench
	input wire logic [28:0] lvl,
	input wire logic [3:0] ir_on,
	// Peripheral side
	output logic [28:0] periph,
	output logic [3:0] ir_clk
);
	assign periph = lvl;
	// Bit clock runs only while encoding, else stands at 0
	always_ff @(posedge ref_clk) begin
		ir_clk <= ir_on & ~ir_clk;
	end
endmodule
`default_nettype wire

/* tb/remappable_pin_select_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module remappable_pin_select_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic osc_wr_en = 1'b0;
	logic [7:0] osc_wr_data = 8'h00;
	logic one_way_lock_config = 1'b0;
	logic pin_select_lock_bit;
	logic sel_wr_en = 1'b0;
	logic sel_wr_is_input = 1'b0;
	logic [4:0] sel_wr_index = 5'h00;
	logic [15:0] sel_wr_data = 16'h0000;
	logic [191:0] pin_output_selector_reg;
	logic [359:0] peripheral_input_selector_reg;
	logic [28:0] lvl = 29'h0;
	logic [3:0] ir_on = 4'h0;
	logic [28:0] periph;
	logic [3:0] ir_clk;
	logic [43:0] remappable_pin_in = 44'h0;
	logic [31:0] remappable_pin_out;
	logic [31:0] remappable_pin_oe_n;
	logic [59:0] peripheral_in;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	int k;

	rps_periph_model model (.ref_clk, .lvl, .ir_on, .periph, .ir_clk);

	// Pin 6 left out to exercise absent pins
	rps_top #(.IMPL_PIN_MASK(64'h0000_0FFF_FFFF_FFBF)) dut (
		.ref_clk, .rst_n, .osc_wr_en, .osc_wr_data, .one_way_lock_config,
		.pin_select_lock_bit, .sel_wr_en, .sel_wr_is_input, .sel_wr_index, .sel_wr_data,
		.pin_output_selector_reg, .peripheral_input_selector_reg,
		.comparator_one_out(periph[0]), .comparator_two_out(periph[1]),
		.comparator_three_out(periph[2]),
		.serial_one_transmit(periph[3]), .serial_one_request_to_send(periph[4]),
		.serial_two_transmit(periph[5]), .serial_two_request_to_send(periph[6]),
		.serial_three_transmit(periph[7]), .serial_three_request_to_send(periph[8]),
		.serial_four_transmit(periph[9]), .serial_four_request_to_send(periph[10]),
		.spi_one_data_out(periph[11]), .spi_one_clock_out(periph[12]),
		.spi_one_select_out(periph[13]), .spi_two_data_out(periph[14]),
		.spi_two_clock_out(periph[15]), .spi_two_select_out(periph[16]),
		.spi_three_data_out(periph[17]), .spi_three_clock_out(periph[18]),
		.spi_three_select_out(periph[19]), .compare_unit_out(periph[28:20]),
		.infrared_active(ir_on), .infrared_bit_clock(ir_clk),
		.remappable_pin_in, .remappable_pin_out, .remappable_pin_oe_n, .peripheral_in
	);

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 5000) begin
			error_cnt++;
			close_out();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk_vec(input string nm, input logic [359:0] e, input logic [359:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic osc_wr(input logic [7:0] d);
		@(negedge ref_clk);
		osc_wr_en = 1'b1;
		osc_wr_data = d;
		@(negedge ref_clk);
		osc_wr_en = 1'b0;
	endtask

	// Other bits set on the third write when clearing, to prove only bit 6 counts
	task automatic lock_seq(input logic v);
		osc_wr(8'h46);
		osc_wr(8'h57);
		osc_wr(v ? 8'h40 : 8'hBF);
		step(1);
	endtask

	task automatic sel_wr(input logic is_in, input logic [4:0] idx, input logic [5:0] hi,
			input logic [5:0] lo);
		@(negedge ref_clk);
		sel_wr_en = 1'b1;
		sel_wr_is_input = is_in;
		sel_wr_index = idx;
		sel_wr_data = {2'b00, hi, 2'b00, lo};
		@(negedge ref_clk);
		sel_wr_en = 1'b0;
		step(1);
	endtask

	task automatic chk_rst();
		chk_vec("in_sel", {60{6'h3F}}, peripheral_input_selector_reg);
		chk_vec("out_sel", 360'h0, 360'(pin_output_selector_reg));
		chk_vec("oe_n", 360'(32'hFFFF_FFFF), 360'(remappable_pin_oe_n));
		chk_vec("pin_out", 360'h0, 360'(remappable_pin_out));
		chk_vec("periph_in", 360'h0, 360'(peripheral_in));
		chk_bit("lock", 1'b0, pin_select_lock_bit);
	endtask

	// Source index on the model for each output code, -1 for none
	function automatic int exp_idx(input int c);
		case (c) inside
			1: return 0;
			2: return 1;
			36: return 2;
			[3:6]: return c;
			[28:31]: return c - 21;
			[7:12]: return c + 4;
			[32:34]: return c - 15;
			[18:25]: return c + 2;
			35: return 28;
			default: return -1;
		endcase
	endfunction

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		step(6);
		rst_n = 1'b1;
		step(1);
		chk_rst();
		$display("test reset done");

		// Every output code on two pins at once
		for (int c = 0; c < 64; c++) begin
			sel_wr(1'b0, 5'h00, 6'(c), 6'(c));
			k = exp_idx(c);
			lvl = (k < 0) ? 29'h1FFF_FFFF : (29'h1 << k);
			step(1);
			chk_vec("pin_out", 360'({2{k >= 0}}), 360'(remappable_pin_out[1:0]));
			chk_vec("oe_n", 360'({2{k < 0}}), 360'(remappable_pin_oe_n[1:0]));
			if (k >= 0) begin
				lvl = ~(29'h1 << k);
				step(1);
				chk_vec("pin_out", 360'h0, 360'(remappable_pin_out[1:0]));
			end
		end
		$display("test output codes done");

		sel_wr(1'b0, 5'h00, rps_pkg::CODE_SER1_RTS, rps_pkg::CODE_SER1_RTS);
		sel_wr(1'b0, 5'h01, rps_pkg::CODE_SER3_RTS, rps_pkg::CODE_SER3_RTS);
		lvl = 29'h110;
		ir_on = 4'h5;
		repeat (4) begin
			step(1);
			chk_bit("ir_pin0", ~ir_clk[0], remappable_pin_out[0]);
			chk_bit("ir_pin2", ~ir_clk[2], remappable_pin_out[2]);
		end
		ir_on = 4'h0;
		$display("test infrared done");

		sel_wr(1'b1, 5'h00, 6'h2B, 6'h05);
		sel_wr(1'b1, 5'h01, 6'h05, 6'h05);
		remappable_pin_in = 44'hFFF_FFFF_FFFF;
		step(1);
		chk_vec("periph_in", 360'(4'hF), 360'(peripheral_in[3:0]));
		remappable_pin_in = ~44'h800_0000_0020;
		step(1);
		chk_vec("periph_in", 360'h0, 360'(peripheral_in[3:0]));
		remappable_pin_in = 44'hFFF_FFFF_FFFF;
		sel_wr(1'b1, 5'h00, 6'h2C, 6'h06);
		chk_vec("in_sel", 360'({6'h2C, 6'h06}), 360'(peripheral_input_selector_reg[11:0]));
		step(1);
		chk_vec("periph_in", 360'h0, 360'(peripheral_in[1:0]));
		sel_wr(1'b0, 5'h03, 6'h03, 6'h03);
		chk_vec("out_sel", 360'({6'h03, 6'h00}), 360'(pin_output_selector_reg[47:36]));
		$display("test input map done");

		lock_seq(1'b1);
		chk_bit("lock", 1'b1, pin_select_lock_bit);
		sel_wr(1'b0, 5'h00, 6'h01, 6'h01);
		chk_vec("out_sel", 360'({6'h04, 6'h04}), 360'(pin_output_selector_reg[11:0]));
		osc_wr(8'h46);
		osc_wr(8'h00);
		osc_wr(8'h57);
		osc_wr(8'hBF);
		step(1);
		chk_bit("lock", 1'b1, pin_select_lock_bit);
		lock_seq(1'b0);
		sel_wr(1'b0, 5'h00, 6'h01, 6'h02);
		sel_wr(1'b0, 5'h01, 6'h24, 6'h23);
		step(20);
		chk_bit("lock", 1'b0, pin_select_lock_bit);
		chk_vec("out_sel", 360'(24'h923042), 360'(pin_output_selector_reg[23:0]));
		$display("test lock done");

		one_way_lock_config = 1'b1;
		lock_seq(1'b1);
		lock_seq(1'b0);
		chk_bit("lock", 1'b1, pin_select_lock_bit);
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		step(1);
		chk_rst();
		$display("test one way done");
		close_out();
	end
endmodule
`default_nettype wire
